// ### logic/weigh_consts.svh
// Register indices, field values, reset values and timing counts of the weighing parameter bank.
`ifndef WEIGH_CONSTS_SVH
`define WEIGH_CONSTS_SVH
// ==========================================================================
// Parameter indices, each the high word of a pair; the low word sits at +1.
`define IDX_FILTER_LEVEL 16'h2106
`define IDX_OUTPUT_STATES 16'h210a
`define IDX_INPUT_STATES 16'h210c
`define IDX_FILTER_KIND 16'h2110
`define IDX_STILL_BAND 16'h2112
`define IDX_STILL_DWELL 16'h2114
`define IDX_GATE_MASK 16'h2116
`define IDX_TARE_READBACK 16'h2118
`define IDX_AVG_EXP 16'h2120
`define IDX_ZERO_FOLLOW 16'h2122
`define IDX_SMOOTHING 16'h212a
`define IDX_PRESET_TARE 16'h212c
`define IDX_ABS_SPAN 16'h2200
`define IDX_ABS_NULL 16'h2202
`define IDX_CAL_UNLOCK 16'h2204
`define IDX_SPAN_CAL 16'h2206
`define IDX_UPPER_LIMIT 16'h220c
`define IDX_LOWER_LIMIT 16'h220e
`define IDX_NULL_CAL 16'h2212
`define IDX_RADIX 16'h2214
`define IDX_DISP_INC 16'h2216
`define IDX_RANGE_SEL 16'h2218
`define IDX_SECOND_MAX 16'h221a
`define IDX_IRQ_STATUS 16'h2300
`define IDX_IRQ_CLEAR 16'h2302
`define IDX_IRQ_ENABLE 16'h2304
// ==========================================================================
// Value limits, reset values, field positions.
`define FILTER_LEVEL_MAX 32'h8
`define FILTER_KIND_MAX 32'h1
`define AVG_EXP_MAX 32'h7
`define ZERO_FOLLOW_MAX 32'hff
`define UPPER_RST 32'h7fffffff
`define LOWER_RST 32'h80000000
`define MASK_RST 32'h000000ff
`define PIN_COUNT 8
`define FIR_TAPS 8
`define QUAL_UNDER 16'h0001
`define QUAL_OVER 16'h0002
`define QUAL_STILL 16'h0010
`define IRQ_BITS 3
`define IRQ_RESULT 0
`define IRQ_STILL 1
`define IRQ_REFUSED 2
// ==========================================================================
// Timing.
`define CLK_NS 5
`define MS_NS 1000000
`endif

// ### logic/weigh_pkg.sv
// Types shared by the weighing parameter bank.
package weigh_pkg;
  typedef enum logic [4:0] {
    SL_FILTER_LEVEL, SL_OUTPUT_STATES, SL_INPUT_STATES, SL_FILTER_KIND,
    SL_STILL_BAND, SL_STILL_DWELL, SL_GATE_MASK, SL_TARE_READBACK,
    SL_AVG_EXP, SL_ZERO_FOLLOW, SL_SMOOTHING, SL_PRESET_TARE,
    SL_ABS_SPAN, SL_ABS_NULL, SL_CAL_UNLOCK, SL_SPAN_CAL,
    SL_UPPER_LIMIT, SL_LOWER_LIMIT, SL_NULL_CAL, SL_RADIX,
    SL_DISP_INC, SL_RANGE_SEL, SL_SECOND_MAX, SL_IRQ_STATUS,
    SL_IRQ_CLEAR, SL_IRQ_ENABLE, SL_NONE
  } slot_t;
  typedef enum logic {WP_IDLE, WP_HIGH} pair_state_t;
  localparam int NUM_SLOTS = 26;
endpackage : weigh_pkg

// ### logic/still_detect.sv
// No-motion detector: weight held inside a band for a dwell time in milliseconds.
`timescale 1ns/1ps
`include "weigh_consts.svh"
module still_detect #(
  parameter int CYCLES_PER_MS = `MS_NS / `CLK_NS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Results and limits
  input wire logic signed [31:0] weight_in,
  input wire logic valid_in,
  input wire logic [31:0] band_in,
  input wire logic [31:0] dwell_ms_in,
  // Verdict
  output logic still_out
);
  logic signed [31:0] ref_ff, nxt_ref;
  logic [31:0] tick_ff, nxt_tick;
  logic [31:0] dwell_ff, nxt_dwell;
  logic inband_ff, nxt_inband;
  logic still_ff, nxt_still;
  logic signed [32:0] diff;
  logic [32:0] mag;
  logic tick;

  // ==========================================================================
  // Band check and dwell timing.
  always_comb
  begin
    diff = {weight_in[31], weight_in} - {ref_ff[31], ref_ff};
    mag = diff[32] ? 33'(-diff) : 33'(diff);
    tick = (tick_ff == 32'(CYCLES_PER_MS - 1));
    nxt_tick = tick ? 32'h0 : tick_ff + 32'h1;
    nxt_ref = ref_ff;
    nxt_inband = inband_ff;
    nxt_dwell = dwell_ff;
    if (tick && inband_ff && dwell_ff < dwell_ms_in)
      nxt_dwell = dwell_ff + 32'h1;
    if (valid_in && mag > {1'b0, band_in})
    begin
      // A step out of the band restarts the dwell around the new weight.
      nxt_ref = weight_in;
      nxt_dwell = 32'h0;
      nxt_inband = 1'b1;
    end
    nxt_still = nxt_inband && (nxt_dwell >= dwell_ms_in) && !(valid_in && mag > {1'b0, band_in});
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ref_ff <= 32'h0;
      tick_ff <= 32'h0;
      dwell_ff <= 32'h0;
      inband_ff <= 1'b0;
      still_ff <= 1'b0;
    end
    else
    begin
      ref_ff <= nxt_ref;
      tick_ff <= nxt_tick;
      dwell_ff <= nxt_dwell;
      inband_ff <= nxt_inband;
      still_ff <= nxt_still;
    end
  end

  assign still_out = still_ff;

  property p_still_dwell;
    @(posedge clk_in) disable iff (reset_in)
    $rose(still_ff) |-> $past(dwell_ms_in == 32'h0 || dwell_ff != 32'h0 || nxt_dwell >= dwell_ms_in);
  endproperty
  a_still_dwell: assert property (p_still_dwell) else $error("still raised before dwell elapsed");

  property p_still_drop;
    @(posedge clk_in) disable iff (reset_in)
    valid_in && mag > {1'b0, band_in} |=> !still_ff;
  endproperty
  a_still_drop: assert property (p_still_drop) else $error("still kept after leaving band");
endmodule : still_detect

// ### logic/weighing_parameter_register_bank.sv
// Parameter register bank and weight datapath of a digital weighing sensor.
`timescale 1ns/1ps
`include "weigh_consts.svh"
// Notes on behaviour
// - Every parameter is 32 bits, moved as two 16-bit words from its index.
// - Filter level takes 0 to 8 and sets low-pass strength on the weight.
// - Filter kind 0 picks IIR, 1 picks FIR; other values refused.
// - Output states read back pin levels; a write changes the pins.
// - Input states is read-only and returns the synchronised input pins.
// - No-motion only after weight stays inside band for the dwell time.
// - Output gate mask is read-write and gates the logic outputs.
// - Tare readback is read-only and returns the active tare.
// - Averaging exponent 0 to 7 averages 1 to 128 filtered samples.
// - Zero follow takes 0 to 255 and needs calibration enabled.
// - Smoothing switch turns the pre-filter stage on or off.
// - Absolute span and null points are read-write, lock guarded.
// - Writing calibration unlock enables the calibration functions.
// - Null calibration is write-only and sets the zero point, lock guarded.
// - Span calibration write sets the gain value, lock guarded.
// - Upper and lower output limits clamp the result, lock guarded.
// - Radix position and display increment are stored, lock guarded.
// - No-motion sets 0x0010 in the qualifier word.
module weighing_parameter_register_bank
  import weigh_pkg::*;
#(
  parameter int CYCLES_PER_MS = `MS_NS / `CLK_NS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Weight samples
  input wire logic signed [31:0] sample_in,
  input wire logic sample_valid_in,
  // Pins
  input wire logic [`PIN_COUNT-1:0] input_pins_in,
  output logic [`PIN_COUNT-1:0] output_pins_out,
  // Results
  output logic signed [31:0] weight_out,
  output logic [15:0] qualifier_out,
  output logic result_valid_out,
  output logic irq_out
);
  // ==========================================================================
  // Decoding.
  function automatic slot_t slot_of(input logic [15:0] a);
    case ({a[15:1], 1'b0})
      `IDX_FILTER_LEVEL: slot_of = SL_FILTER_LEVEL;
      `IDX_OUTPUT_STATES: slot_of = SL_OUTPUT_STATES;
      `IDX_INPUT_STATES: slot_of = SL_INPUT_STATES;
      `IDX_FILTER_KIND: slot_of = SL_FILTER_KIND;
      `IDX_STILL_BAND: slot_of = SL_STILL_BAND;
      `IDX_STILL_DWELL: slot_of = SL_STILL_DWELL;
      `IDX_GATE_MASK: slot_of = SL_GATE_MASK;
      `IDX_TARE_READBACK: slot_of = SL_TARE_READBACK;
      `IDX_AVG_EXP: slot_of = SL_AVG_EXP;
      `IDX_ZERO_FOLLOW: slot_of = SL_ZERO_FOLLOW;
      `IDX_SMOOTHING: slot_of = SL_SMOOTHING;
      `IDX_PRESET_TARE: slot_of = SL_PRESET_TARE;
      `IDX_ABS_SPAN: slot_of = SL_ABS_SPAN;
      `IDX_ABS_NULL: slot_of = SL_ABS_NULL;
      `IDX_CAL_UNLOCK: slot_of = SL_CAL_UNLOCK;
      `IDX_SPAN_CAL: slot_of = SL_SPAN_CAL;
      `IDX_UPPER_LIMIT: slot_of = SL_UPPER_LIMIT;
      `IDX_LOWER_LIMIT: slot_of = SL_LOWER_LIMIT;
      `IDX_NULL_CAL: slot_of = SL_NULL_CAL;
      `IDX_RADIX: slot_of = SL_RADIX;
      `IDX_DISP_INC: slot_of = SL_DISP_INC;
      `IDX_RANGE_SEL: slot_of = SL_RANGE_SEL;
      `IDX_SECOND_MAX: slot_of = SL_SECOND_MAX;
      `IDX_IRQ_STATUS: slot_of = SL_IRQ_STATUS;
      `IDX_IRQ_CLEAR: slot_of = SL_IRQ_CLEAR;
      `IDX_IRQ_ENABLE: slot_of = SL_IRQ_ENABLE;
      default: slot_of = SL_NONE;
    endcase
  endfunction : slot_of

  function automatic logic write_ok(input slot_t s, input logic [31:0] v, input logic unlocked);
    case (s)
      SL_FILTER_LEVEL: write_ok = (v <= `FILTER_LEVEL_MAX);
      SL_FILTER_KIND: write_ok = (v <= `FILTER_KIND_MAX);
      SL_AVG_EXP: write_ok = (v <= `AVG_EXP_MAX);
      SL_ZERO_FOLLOW: write_ok = unlocked && (v <= `ZERO_FOLLOW_MAX);
      SL_ABS_SPAN, SL_ABS_NULL: write_ok = unlocked;
      SL_SPAN_CAL: write_ok = unlocked;
      SL_NULL_CAL: write_ok = unlocked;
      SL_UPPER_LIMIT, SL_LOWER_LIMIT: write_ok = unlocked;
      SL_RADIX, SL_DISP_INC: write_ok = unlocked;
      SL_INPUT_STATES, SL_TARE_READBACK, SL_IRQ_STATUS, SL_NONE: write_ok = 1'b0;
      default: write_ok = 1'b1;
    endcase
  endfunction : write_ok

  function automatic logic [31:0] reset_value(input int i);
    case (i)
      SL_UPPER_LIMIT: reset_value = `UPPER_RST;
      SL_LOWER_LIMIT: reset_value = `LOWER_RST;
      SL_GATE_MASK: reset_value = `MASK_RST;
      default: reset_value = 32'h0;
    endcase
  endfunction : reset_value

  // ==========================================================================
  // Input pin synchroniser.
  logic [`PIN_COUNT-1:0] pin_meta_ff, pin_sync_ff;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= input_pins_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ==========================================================================
  // Register access: word pairing, storage, read port.
  logic [31:0] param_ff [NUM_SLOTS];
  logic [31:0] nxt_param [NUM_SLOTS];
  pair_state_t pair_ff, nxt_pair;
  logic [14:0] pair_base_ff, nxt_pair_base;
  logic [15:0] hi_ff, nxt_hi;
  logic [15:0] rdata_ff, nxt_rdata;
  logic cal_en_ff, nxt_cal_en;
  logic [`IRQ_BITS-1:0] status_ff, nxt_status, irq_set;
  logic [`PIN_COUNT-1:0] pins_ff, nxt_pins;
  logic irq_ff, nxt_irq;
  slot_t wslot, rslot, tslot;
  logic [31:0] wval, rval;
  logic commit, accept, refused;

  always_comb
  begin
    wslot = slot_of(addr_in);
    rslot = slot_of(addr_in);
    wval = {hi_ff, wdata_in};
    // The low word commits the pair; a lone low word is refused.
    commit = wr_in && addr_in[0] && (pair_ff == WP_HIGH) && (pair_base_ff == addr_in[15:1]);
    accept = commit && write_ok(wslot, wval, cal_en_ff);
    refused = wr_in && addr_in[0] && !accept;
    tslot = (wslot == SL_NULL_CAL) ? SL_ABS_NULL : wslot;
    nxt_pair = pair_ff;
    nxt_pair_base = pair_base_ff;
    nxt_hi = hi_ff;
    if (wr_in && !addr_in[0])
    begin
      nxt_pair = WP_HIGH;
      nxt_pair_base = addr_in[15:1];
      nxt_hi = wdata_in;
    end
    else if (wr_in)
      nxt_pair = WP_IDLE;
    for (int i = 0; i < NUM_SLOTS; i++)
      nxt_param[i] = param_ff[i];
    if (accept && tslot != SL_IRQ_CLEAR && tslot != SL_CAL_UNLOCK)
      nxt_param[tslot] = wval;
    nxt_cal_en = cal_en_ff || (accept && wslot == SL_CAL_UNLOCK);
    nxt_pins = param_ff[SL_OUTPUT_STATES][`PIN_COUNT-1:0] & param_ff[SL_GATE_MASK][`PIN_COUNT-1:0];
    case (rslot)
      SL_OUTPUT_STATES: rval = {24'h0, pins_ff};
      SL_INPUT_STATES: rval = {24'h0, pin_sync_ff};
      SL_TARE_READBACK: rval = param_ff[SL_PRESET_TARE];
      SL_CAL_UNLOCK: rval = {31'h0, cal_en_ff};
      SL_IRQ_STATUS: rval = {29'h0, status_ff};
      SL_NULL_CAL, SL_IRQ_CLEAR, SL_NONE: rval = 32'h0;
      default: rval = param_ff[rslot];
    endcase
    nxt_rdata = rd_in ? (addr_in[0] ? rval[15:0] : rval[31:16]) : 16'h0;
    // Set wins over a clear in the same cycle.
    nxt_status = (accept && wslot == SL_IRQ_CLEAR) ? (status_ff & ~wval[`IRQ_BITS-1:0]) : status_ff;
    nxt_status = nxt_status | irq_set;
    nxt_irq = |(nxt_status & param_ff[SL_IRQ_ENABLE][`IRQ_BITS-1:0]);
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
        param_ff[i] <= reset_value(i);
      pair_ff <= WP_IDLE;
      pair_base_ff <= 15'h0;
      hi_ff <= 16'h0;
      rdata_ff <= 16'h0;
      cal_en_ff <= 1'b0;
      status_ff <= '0;
      pins_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      param_ff <= nxt_param;
      pair_ff <= nxt_pair;
      pair_base_ff <= nxt_pair_base;
      hi_ff <= nxt_hi;
      rdata_ff <= nxt_rdata;
      cal_en_ff <= nxt_cal_en;
      status_ff <= nxt_status;
      pins_ff <= nxt_pins;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================================
  // Weight datapath: pre-filter, low-pass, averaging, offset and clamp.
  logic signed [31:0] prev_ff, nxt_prev, pf_ff, nxt_pf, iir_ff, nxt_iir, flt_ff, nxt_flt;
  logic signed [31:0] hist_ff [`FIR_TAPS], nxt_hist [`FIR_TAPS];
  logic signed [39:0] acc_ff, nxt_acc;
  logic [7:0] cnt_ff, nxt_cnt;
  logic signed [31:0] avg_ff, nxt_avg, wt_ff, nxt_wt;
  logic pf_v_ff, flt_v_ff, avg_v_ff, res_v_ff;
  logic [15:0] qual_ff, nxt_qual;
  logic signed [32:0] pf_sum, iir_diff;
  logic signed [34:0] fir_sum;
  logic signed [39:0] acc_sum;
  logic signed [31:0] net;
  logic [1:0] fir_shift;
  logic [2:0] avg_exp;
  logic [3:0] lvl;
  logic still, still_d_ff;

  always_comb
  begin
    nxt_prev = sample_valid_in ? sample_in : prev_ff;
    pf_sum = {sample_in[31], sample_in} + {prev_ff[31], prev_ff};
    nxt_pf = (param_ff[SL_SMOOTHING] != 32'h0) ? pf_sum[32:1] : sample_in;
    lvl = param_ff[SL_FILTER_LEVEL][3:0];
    fir_shift = (lvl > 4'h3) ? 2'h3 : lvl[1:0];
    for (int i = 0; i < `FIR_TAPS; i++)
      nxt_hist[i] = hist_ff[i];
    nxt_iir = iir_ff;
    if (pf_v_ff)
    begin
      nxt_hist[0] = pf_ff;
      for (int i = 1; i < `FIR_TAPS; i++)
        nxt_hist[i] = hist_ff[i-1];
      iir_diff = {pf_ff[31], pf_ff} - {iir_ff[31], iir_ff};
      nxt_iir = iir_ff + 32'(iir_diff >>> lvl);
    end
    else
      iir_diff = 33'h0;
    fir_sum = 35'h0;
    for (int i = 0; i < `FIR_TAPS; i++)
      if (i < (1 << fir_shift))
        fir_sum = fir_sum + 35'(nxt_hist[i]);
    nxt_flt = param_ff[SL_FILTER_KIND][0] ? 32'(fir_sum >>> fir_shift) : nxt_iir;
    avg_exp = param_ff[SL_AVG_EXP][2:0];
    acc_sum = acc_ff + 40'(flt_ff);
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_avg = avg_ff;
    if (flt_v_ff)
    begin
      if (cnt_ff == ((8'h1 << avg_exp) - 8'h1))
      begin
        nxt_avg = 32'(acc_sum >>> avg_exp);
        nxt_acc = 40'h0;
        nxt_cnt = 8'h0;
      end
      else
      begin
        nxt_acc = acc_sum;
        nxt_cnt = cnt_ff + 8'h1;
      end
    end
    net = avg_ff - $signed(param_ff[SL_ABS_NULL]) - $signed(param_ff[SL_PRESET_TARE]);
    nxt_wt = wt_ff;
    nxt_qual = qual_ff;
    if (avg_v_ff)
    begin
      nxt_wt = net;
      nxt_qual = 16'h0;
      if (net > $signed(param_ff[SL_UPPER_LIMIT]))
      begin
        nxt_wt = $signed(param_ff[SL_UPPER_LIMIT]);
        nxt_qual = `QUAL_OVER;
      end
      else if (net < $signed(param_ff[SL_LOWER_LIMIT]))
      begin
        nxt_wt = $signed(param_ff[SL_LOWER_LIMIT]);
        nxt_qual = `QUAL_UNDER;
      end
    end
    nxt_qual = (nxt_qual & ~`QUAL_STILL) | (still ? `QUAL_STILL : 16'h0);
    irq_set = '0;
    irq_set[`IRQ_RESULT] = res_v_ff;
    irq_set[`IRQ_STILL] = still && !still_d_ff;
    irq_set[`IRQ_REFUSED] = refused;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prev_ff <= 32'sh0;
      pf_ff <= 32'sh0;
      iir_ff <= 32'sh0;
      flt_ff <= 32'sh0;
      for (int i = 0; i < `FIR_TAPS; i++)
        hist_ff[i] <= 32'sh0;
      acc_ff <= 40'sh0;
      cnt_ff <= 8'h0;
      avg_ff <= 32'sh0;
      wt_ff <= 32'sh0;
      qual_ff <= 16'h0;
      pf_v_ff <= 1'b0;
      flt_v_ff <= 1'b0;
      avg_v_ff <= 1'b0;
      res_v_ff <= 1'b0;
      still_d_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev;
      pf_ff <= sample_valid_in ? nxt_pf : pf_ff;
      iir_ff <= nxt_iir;
      flt_ff <= pf_v_ff ? nxt_flt : flt_ff;
      hist_ff <= nxt_hist;
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      avg_ff <= nxt_avg;
      wt_ff <= nxt_wt;
      qual_ff <= nxt_qual;
      pf_v_ff <= sample_valid_in;
      flt_v_ff <= pf_v_ff;
      avg_v_ff <= flt_v_ff && (cnt_ff == ((8'h1 << avg_exp) - 8'h1));
      res_v_ff <= avg_v_ff;
      still_d_ff <= still;
    end
  end

  still_detect #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_still (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .weight_in(wt_ff),
    .valid_in(res_v_ff),
    .band_in(param_ff[SL_STILL_BAND]),
    .dwell_ms_in(param_ff[SL_STILL_DWELL]),
    .still_out(still)
  );

  assign rdata_out = rdata_ff;
  assign output_pins_out = pins_ff;
  assign weight_out = wt_ff;
  assign qualifier_out = qual_ff;
  assign result_valid_out = res_v_ff;
  assign irq_out = irq_ff;

  // ==========================================================================
  // Checks.
  property p_level_range;
    @(posedge clk_in) disable iff (reset_in)
    param_ff[SL_FILTER_LEVEL] <= `FILTER_LEVEL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("filter level above range");

  property p_kind_range;
    @(posedge clk_in) disable iff (reset_in)
    commit && wslot == SL_FILTER_KIND && wval > `FILTER_KIND_MAX |=> $stable(param_ff[SL_FILTER_KIND]);
  endproperty
  a_kind_range: assert property (p_kind_range) else $error("illegal filter kind stored");

  property p_avg_count;
    @(posedge clk_in) disable iff (reset_in)
    avg_v_ff |-> $past(cnt_ff) == ((8'h1 << $past(avg_exp)) - 8'h1);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("average built from wrong count");

  property p_lock_guard;
    @(posedge clk_in) disable iff (reset_in)
    commit && !cal_en_ff && wslot == SL_SPAN_CAL |=> $stable(param_ff[SL_SPAN_CAL]);
  endproperty
  a_lock_guard: assert property (p_lock_guard) else $error("locked span changed");

  property p_unlock;
    @(posedge clk_in) disable iff (reset_in)
    commit && wslot == SL_CAL_UNLOCK |=> cal_en_ff;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock write did not enable");

  property p_output_write;
    @(posedge clk_in) disable iff (reset_in)
    commit && wslot == SL_OUTPUT_STATES ##0 param_ff[SL_GATE_MASK] == `MASK_RST
      |-> ##2 output_pins_out == $past(wdata_in[`PIN_COUNT-1:0], 2);
  endproperty
  a_output_write: assert property (p_output_write) else $error("output pins missed write");

  property p_input_read;
    @(posedge clk_in) disable iff (reset_in)
    rd_in && addr_in == (`IDX_INPUT_STATES + 16'h1) |=> rdata_out == {8'h0, $past(pin_sync_ff)};
  endproperty
  a_input_read: assert property (p_input_read) else $error("input read wrong");

  property p_still_flag;
    @(posedge clk_in) disable iff (reset_in)
    still |=> qualifier_out[4];
  endproperty
  a_still_flag: assert property (p_still_flag) else $error("qualifier misses still bit");

  property p_readonly;
    @(posedge clk_in) disable iff (reset_in)
    commit && wslot == SL_TARE_READBACK |=> !$changed(param_ff[SL_PRESET_TARE]);
  endproperty
  a_readonly: assert property (p_readonly) else $error("read-only write took effect");
endmodule : weighing_parameter_register_bank

// ### tb/sensor_model.sv
// Model of the load cell front end: weight samples and physical input pin levels.
`timescale 1ns/1ps
module sensor_model (
  // Clock
  input wire logic clk_in,
  // Samples and pins
  output logic signed [31:0] sample_out,
  output logic sample_valid_out,
  output logic [7:0] pins_out
);
  initial
  begin
    sample_out = 32'h0;
    sample_valid_out = 1'b0;
    pins_out = 8'h00;
  end
  // =====================================================================
  // A released sample bus shows the inverse value, so a stale read is caught.
  task automatic send(input logic signed [31:0] w);
    @(posedge clk_in);
    sample_out <= w;
    sample_valid_out <= 1'b1;
    @(posedge clk_in);
    sample_out <= ~w;
    sample_valid_out <= 1'b0;
  endtask : send
  task automatic set_pins(input logic [7:0] p);
    @(posedge clk_in);
    pins_out <= p;
  endtask : set_pins
endmodule : sensor_model

// ### tb/tb_top.sv
// Self-checking bench of the weighing parameter register bank.
`timescale 1ns/1ps
`include "weigh_consts.svh"
module tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] addr_in = 16'h0;
  logic [15:0] wdata_in = 16'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic signed [31:0] sample_in;
  logic sample_valid_in;
  logic [7:0] pins;
  logic [7:0] output_pins_out;
  logic signed [31:0] weight_out;
  logic [15:0] qualifier_out;
  logic result_valid_out;
  logic irq_out;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 clk_in = ~clk_in;
  sensor_model partner (.clk_in(clk_in), .sample_out(sample_in), .sample_valid_out(sample_valid_in), .pins_out(pins));
  weighing_parameter_register_bank #(.CYCLES_PER_MS(4)) dut (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sample_in(sample_in), .sample_valid_in(sample_valid_in), .input_pins_in(pins),
    .output_pins_out(output_pins_out), .weight_out(weight_out), .qualifier_out(qualifier_out),
    .result_valid_out(result_valid_out), .irq_out(irq_out));
  // =====================================================================
  // Bus tasks and comparison.
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic wr32(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v[31:16];
    @(posedge clk_in);
    addr_in <= a + 16'h1;
    wdata_in <= v[15:0];
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    addr_in <= a + 16'h1;
    #1 v[31:16] = rdata_out;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v[15:0] = rdata_out;
  endtask : rd32
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd32(a, v);
    chk(exp, v);
  endtask : rchk
  // =====================================================================
  // Scenarios.
  task automatic t_weight();
    int i;
    partner.send(32'sd100);
    for (i = 0; i < 10 && result_valid_out !== 1'b1; i++)
      @(posedge clk_in) #1;
    chk(32'h1, result_valid_out);
    chk(32'd100, weight_out);
  endtask : t_weight
  task automatic t_still();
    int i;
    wr32(`IDX_STILL_BAND, 32'ha);
    wr32(`IDX_STILL_DWELL, 32'h2);
    partner.send(32'sd200);
    for (i = 0; i < 10 && result_valid_out !== 1'b1; i++)
      @(posedge clk_in) #1;
    chk(32'd200, weight_out);
    repeat (3) @(posedge clk_in);
    #1 chk(32'h0, qualifier_out);
    repeat (12) @(posedge clk_in);
    #1 chk(`QUAL_STILL, qualifier_out);
  endtask : t_still
  task automatic t_values();
    rchk(`IDX_UPPER_LIMIT, `UPPER_RST);
    rchk(`IDX_GATE_MASK, `MASK_RST);
    wr32(`IDX_AVG_EXP, 32'h7);
    rchk(`IDX_AVG_EXP, 32'h7);
    wr32(`IDX_AVG_EXP, 32'h8);
    rchk(`IDX_AVG_EXP, 32'h7);
    wr32(`IDX_FILTER_KIND, 32'h2);
    rchk(`IDX_FILTER_KIND, 32'h0);
    wr32(`IDX_FILTER_KIND, 32'h1);
    rchk(`IDX_FILTER_KIND, 32'h1);
    wr32(`IDX_FILTER_LEVEL, 32'h8);
    rchk(`IDX_FILTER_LEVEL, 32'h8);
    wr32(`IDX_SMOOTHING, 32'h1);
    rchk(`IDX_SMOOTHING, 32'h1);
  endtask : t_values
  task automatic t_readonly_irq();
    partner.set_pins(8'ha5);
    wr32(`IDX_IRQ_ENABLE, 32'h4);
    wr32(`IDX_IRQ_CLEAR, 32'h7);
    repeat (2) @(posedge clk_in);
    #1 chk(1'b0, irq_out);
    rchk(`IDX_INPUT_STATES, 32'ha5);
    wr32(`IDX_INPUT_STATES, 32'h1);
    rchk(`IDX_INPUT_STATES, 32'ha5);
    chk(1'b1, irq_out);
    wr32(`IDX_PRESET_TARE, 32'h7);
    wr32(`IDX_TARE_READBACK, 32'h3);
    rchk(`IDX_TARE_READBACK, 32'h7);
    wr32(`IDX_IRQ_CLEAR, 32'h4);
    repeat (2) @(posedge clk_in);
    #1 chk(1'b0, irq_out);
  endtask : t_readonly_irq
  task automatic t_lock();
    wr32(`IDX_ABS_NULL, 32'h3);
    rchk(`IDX_ABS_NULL, 32'h0);
    wr32(`IDX_RADIX, 32'h2);
    rchk(`IDX_RADIX, 32'h0);
    wr32(`IDX_SPAN_CAL, 32'h5);
    rchk(`IDX_SPAN_CAL, 32'h0);
    wr32(`IDX_CAL_UNLOCK, 32'h1);
    wr32(`IDX_SPAN_CAL, 32'h5);
    rchk(`IDX_SPAN_CAL, 32'h5);
    wr32(`IDX_ABS_NULL, 32'h3);
    rchk(`IDX_ABS_NULL, 32'h3);
    wr32(`IDX_NULL_CAL, 32'h9);
    rchk(`IDX_ABS_NULL, 32'h9);
    wr32(`IDX_LOWER_LIMIT, 32'hffffff00);
    rchk(`IDX_LOWER_LIMIT, 32'hffffff00);
    wr32(`IDX_ZERO_FOLLOW, 32'h100);
    rchk(`IDX_ZERO_FOLLOW, 32'h0);
    wr32(`IDX_ZERO_FOLLOW, 32'hff);
    rchk(`IDX_ZERO_FOLLOW, 32'hff);
  endtask : t_lock
  task automatic t_outputs();
    wr32(`IDX_OUTPUT_STATES, 32'h5a);
    repeat (2) @(posedge clk_in);
    #1 chk(32'h5a, output_pins_out);
    wr32(`IDX_GATE_MASK, 32'h0f);
    wr32(`IDX_OUTPUT_STATES, 32'hff);
    repeat (2) @(posedge clk_in);
    #1 chk(8'h0f, output_pins_out);
    rchk(`IDX_OUTPUT_STATES, 32'h0f);
  endtask : t_outputs
  // =====================================================================
  // Run control.
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_weight();
    t_still();
    t_values();
    t_readonly_irq();
    t_lock();
    t_outputs();
    finish_test();
  end
endmodule : tb_top
